// ==== core/cpld_fabric_params.svh ====
// offsets, field positions and reset values for the macrocell fabric
`ifndef CPLD_FABRIC_PARAMS_SVH
`define CPLD_FABRIC_PARAMS_SVH

`define MC_PER_GROUP      16
`define GROUP_INPUTS      36
`define TERMS_PER_MC      5
`define CHAIN_LEN         8
`define MAX_PEXP_SETS     3
`define TERM_WORDS        3
`define MC_WORDS          16
`define MODE_WORD         15

`define OFS_CTRL          12'h000
`define OFS_CLKSEL        12'h004
`define OFS_GOE           12'h008
`define OFS_STATUS        12'h00C
`define OFS_INIT          12'h010
`define OFS_ROUTE_PAGE    4'h1
`define OFS_CFG_PAGE      2'h1

`define CTRL_ENHANCED     0
`define CTRL_JTAG         1
`define CTRL_RESET        32'h0000_0001
`define JTAG_PINS         4

`define MF_FT_LO          0
`define MF_BYPASS         2
`define MF_CKM_LO         3
`define MF_GNET           5
`define MF_GCLR           6
`define MF_PU_HIGH        7
`define MF_FAST           8
`define MF_PEXP_LO        9
`define MF_XORP           11
`define MF_SEC_CLR        12
`define MF_SEC_PRE        13
`define MF_SEC_CLK        14
`define MF_SHX            15
`define MF_LEND           16
`define MF_OESEL_LO       17
`define MF_TEN_LO         20

`define OESEL_GND         3'h0
`define OESEL_VCC         3'h1
`define OESEL_GOE0        3'h2

`endif

// ==== core/cpld_fabric_pkg.sv ====
// types shared by the macrocell fabric
package cpld_fabric_pkg;
	typedef enum logic [1:0] {
		FF_D  = 2'h0,
		FF_T  = 2'h1,
		FF_JK = 2'h2,
		FF_SR = 2'h3
	} ff_type_e;

	typedef enum logic [1:0] {
		CK_GLOBAL  = 2'h0,
		CK_GLOB_EN = 2'h1,
		CK_ARRAY   = 2'h2
	} clk_mode_e;
endpackage

// ==== core/cpld_macrocell_register_fabric.sv ====
// one product-term group of macrocells with routing, registers, pin control and an apb config slave
`timescale 1ns/1ps
`include "cpld_fabric_params.svh"

// Notes on behaviour
// - flip-flop per macrocell works as D, T, JK or SR, or is bypassed.
// - five product terms per macrocell feed the OR and XOR path.
// - select matrix sends each term to the OR or to preset, clear or clock controls.
// - first clock mode uses a global clock net with no enable.
// - second mode uses a global clock gated by a term-driven active-high enable.
// - third mode clocks the register from a product term.
// - two global clock nets, each true or inverted of either clock pin.
// - term-driven preset and clear are asynchronous and active high.
// - each clear may also follow the active-low global clear pin.
// - enhanced parts start each register high or low as configured.
// - non-enhanced parts start every register low.
// - sixteen macrocells form a group fed by the global routing array.
// - each group takes 36 routed inputs plus global controls and fast pin paths.
// - each pin has a direct path to its macrocell register D input.
// - expanders let one macrocell reach up to 32 product terms.
// - shareable expanders are inverted terms fed back; parallel ones are borrowed.
// - four dedicated inputs serve as general inputs or global controls.
// - six global output enables by default; NUM_OE of ten builds ten, but pins can select only the first six.
// - in boundary-scan use four pins leave user I/O.
// - sixteen shareable expanders per group, any usable by any macrocell.
// - borrow up to three sets of five from lower macrocells in a chain of eight.
module cpld_macrocell_register_fabric #(
	parameter int NUM_OE = 6
) (
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     global_clock_pin_one,
	input  wire logic                     global_clock_pin_two,
	input  wire logic                     global_clear_pin_low,
	input  wire logic                     oe_pin_one,
	input  wire logic [`MC_PER_GROUP-1:0] io_in,
	output logic      [`MC_PER_GROUP-1:0] io_out,
	output logic      [`MC_PER_GROUP-1:0] io_oe_n
);
	localparam int NMC = `MC_PER_GROUP;
	localparam int NGI = `GROUP_INPUTS;
	localparam int NCW = `MC_PER_GROUP * `MC_WORDS;

	logic [31:0]    ctrl_ff;
	logic [3:0]     clksel_ff;
	logic [19:0]    goe_ff;
	logic           init_ff;
	logic [5:0]     route_ff [NGI];
	logic [31:0]    cfg_ff [NCW];
	logic [NMC-1:0] mc_out;
	logic [NMC-1:0] mc_out_ff;
	logic [NMC-1:0] lend_sum;
	logic [NMC-1:0] lend_en;
	logic [NMC-1:0] share_term;
	logic [NMC-1:0] io_user;
	logic [3:0]     ded_in;
	logic [NGI-1:0] gin;
	logic [1:0]     gnet;
	logic [1:0]     gnet_prev_ff;
	logic [1:0]     gnet_rise;
	logic [9:0]     goe_net;
	logic [31:0]    rd_val;
	logic           rd_hit;
	logic           wr_en;
	logic           is_route;
	logic           is_cfg;

	// apb slave: zero wait states, data captured in the setup cycle
	assign pready   = 1'b1;
	assign wr_en    = psel & penable & pwrite;
	assign is_route = (paddr[11:8] == `OFS_ROUTE_PAGE) && (paddr[7:2] < 6'(NGI));
	assign is_cfg   = (paddr[11:10] == `OFS_CFG_PAGE);
	assign pslverr  = psel & penable & ~rd_hit;

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		if (is_route) begin
			rd_val = {26'h000_0000, route_ff[paddr[7:2]]};
		end else if (is_cfg) begin
			rd_val = cfg_ff[paddr[9:2]];
		end else begin
			case (paddr)
				`OFS_CTRL:   rd_val = ctrl_ff;
				`OFS_CLKSEL: rd_val = {28'h000_0000, clksel_ff};
				`OFS_GOE:    rd_val = {12'h000, goe_ff};
				`OFS_STATUS: rd_val = {16'h0000, mc_out_ff};
				`OFS_INIT:   rd_val = 32'h0000_0000;
				default:     rd_hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= rd_val;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl_ff   <= `CTRL_RESET;
			clksel_ff <= 4'h0;
			goe_ff    <= 20'h0_0000;
			init_ff   <= 1'b0;
		end else begin
			init_ff <= wr_en && (paddr == `OFS_INIT) && pwdata[0];
			if (wr_en && paddr == `OFS_CTRL) begin
				ctrl_ff <= {30'h0000_0000, pwdata[1:0]};
			end
			if (wr_en && paddr == `OFS_CLKSEL) begin
				clksel_ff <= pwdata[3:0];
			end
			if (wr_en && paddr == `OFS_GOE) begin
				goe_ff <= pwdata[19:0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NGI; i++) begin
				route_ff[i] <= 6'h3F;
			end
		end else if (wr_en && is_route) begin
			route_ff[paddr[7:2]] <= pwdata[5:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NCW; i++) begin
				cfg_ff[i] <= 32'h0000_0000;
			end
		end else if (wr_en && is_cfg) begin
			cfg_ff[paddr[9:2]] <= pwdata;
		end
	end

	// global clock nets and their edges seen on sys_clk
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			gnet[i] = (clksel_ff[2*i] ? global_clock_pin_two : global_clock_pin_one) ^ clksel_ff[2*i+1];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gnet_prev_ff <= 2'h0;
		end else begin
			gnet_prev_ff <= gnet;
		end
	end

	assign gnet_rise = gnet & ~gnet_prev_ff;

	// global output enables: true or complement of oe_pin_one or of global_clock_pin_two
	always_comb begin
		goe_net = 10'h000;
		for (int k = 0; k < NUM_OE; k++) begin
			goe_net[k] = (goe_ff[2*k] ? global_clock_pin_two : oe_pin_one) ^ goe_ff[2*k+1];
		end
	end

	// pins taken by boundary scan read as zero to the fabric
	always_comb begin
		io_user = io_in;
		if (ctrl_ff[`CTRL_JTAG]) begin
			io_user[NMC-1 -: `JTAG_PINS] = '0;
		end
	end

	assign ded_in = {oe_pin_one, global_clear_pin_low, global_clock_pin_two, global_clock_pin_one};

	// routing: feedback is taken from the registered output so bypassed cells cannot form loops
	always_comb begin
		for (int i = 0; i < NGI; i++) begin
			case (route_ff[i]) inside
				[6'h00:6'h0F]: gin[i] = io_user[route_ff[i][3:0]];
				[6'h10:6'h1F]: gin[i] = mc_out_ff[route_ff[i][3:0]];
				[6'h20:6'h23]: gin[i] = ded_in[route_ff[i][1:0]];
				default:       gin[i] = 1'b0;
			endcase
		end
	end

	function automatic logic pterm(input logic [31:0] wa, input logic [31:0] wb, input logic [31:0] wc,
	                               input logic [NGI-1:0] g, input logic [NMC-1:0] x, input logic en);
		logic [NGI-1:0] tm;
		logic [NGI-1:0] cm;
		logic [NMC-1:0] em;
		tm    = {wc[3:0], wa};
		cm    = {wc[7:4], wb};
		em    = wc[23:8];
		pterm = en & (&(~tm | g)) & (&(~cm | ~g)) & (&(~em | x));
	endfunction

	genvar m;
	genvar k;
	generate
		for (m = 0; m < NMC; m++) begin : g_mc
			localparam int B = m * `MC_WORDS;
			logic [31:0]     mw;
			logic [4:0]      t;
			logic [4:0]      ten;
			logic            own_or;
			logic [3:1]      bor;
			logic            s;
			logic            d_in;
			logic            clr;
			logic            pre;
			logic            clk_ev;
			logic            t3_prev_ff;
			logic            q_ff;
			logic            nxt_q;
			logic [2:0]      oesel;
			cpld_fabric_pkg::ff_type_e  ft;
			cpld_fabric_pkg::clk_mode_e ckm;

			assign mw    = cfg_ff[B + `MODE_WORD];
			assign ten   = mw[`MF_TEN_LO +: 5];
			assign ft    = cpld_fabric_pkg::ff_type_e'(mw[`MF_FT_LO +: 2]);
			assign ckm   = cpld_fabric_pkg::clk_mode_e'(mw[`MF_CKM_LO +: 2]);
			assign oesel = mw[`MF_OESEL_LO +: 3];

			// term 4 sees no expanders so the shared pool never feeds itself
			for (k = 0; k < `TERMS_PER_MC; k++) begin : g_t
				assign t[k] = pterm(cfg_ff[B + k*`TERM_WORDS], cfg_ff[B + k*`TERM_WORDS + 1],
				                    (k == 4) ? {24'h00_0000, cfg_ff[B + k*`TERM_WORDS + 2][7:0]}
				                             : cfg_ff[B + k*`TERM_WORDS + 2],
				                    gin, share_term, ten[k]);
			end

			assign share_term[m] = ~(mw[`MF_SHX] & t[4]);
			assign own_or = ((ft == cpld_fabric_pkg::FF_D || ft == cpld_fabric_pkg::FF_T) & t[0])
			              | (~mw[`MF_SEC_CLR] & t[1]) | (~mw[`MF_SEC_PRE] & t[2])
			              | (~mw[`MF_SEC_CLK] & t[3]) | (~mw[`MF_SHX] & t[4]);
			assign lend_sum[m] = own_or;
			assign lend_en[m]  = mw[`MF_LEND];

			for (k = 1; k <= `MAX_PEXP_SETS; k++) begin : g_b
				if ((m % `CHAIN_LEN) >= k) begin : g_ok
					assign bor[k] = (mw[`MF_PEXP_LO +: 2] >= 2'(k)) & lend_en[m-k] & lend_sum[m-k];
				end else begin : g_no
					assign bor[k] = 1'b0;
				end
			end

			assign s    = ((own_or & ~mw[`MF_LEND]) | (|bor)) ^ mw[`MF_XORP];
			assign d_in = mw[`MF_FAST] ? io_user[m] : s;
			assign clr  = (mw[`MF_SEC_CLR] & t[1]) | (mw[`MF_GCLR] & ~global_clear_pin_low);
			assign pre  = mw[`MF_SEC_PRE] & t[2];

			always_comb begin
				case (ckm)
					cpld_fabric_pkg::CK_GLOBAL:  clk_ev = gnet_rise[mw[`MF_GNET]];
					cpld_fabric_pkg::CK_GLOB_EN: clk_ev = gnet_rise[mw[`MF_GNET]] & t[3];
					cpld_fabric_pkg::CK_ARRAY:   clk_ev = t[3] & ~t3_prev_ff;
					default:                     clk_ev = 1'b0;
				endcase
			end

			always_comb begin
				case (ft)
					cpld_fabric_pkg::FF_D:  nxt_q = d_in;
					cpld_fabric_pkg::FF_T:  nxt_q = q_ff ^ d_in;
					cpld_fabric_pkg::FF_JK: nxt_q = (d_in & ~q_ff) | (~t[0] & q_ff);
					cpld_fabric_pkg::FF_SR: nxt_q = d_in | (~t[0] & q_ff);
					default:                nxt_q = q_ff;
				endcase
			end

			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					t3_prev_ff <= 1'b0;
				end else begin
					t3_prev_ff <= t[3];
				end
			end

			// clear beats preset; both also act on the output without waiting for an edge
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					q_ff <= 1'b0;
				end else if (init_ff) begin
					q_ff <= ctrl_ff[`CTRL_ENHANCED] & mw[`MF_PU_HIGH];
				end else if (clr) begin
					q_ff <= 1'b0;
				end else if (pre) begin
					q_ff <= 1'b1;
				end else if (clk_ev) begin
					q_ff <= nxt_q;
				end
			end

			assign mc_out[m] = mw[`MF_BYPASS] ? s : (clr ? 1'b0 : (pre ? 1'b1 : q_ff));

			always_comb begin
				case (oesel)
					`OESEL_GND: io_oe_n[m] = 1'b1;
					`OESEL_VCC: io_oe_n[m] = 1'b0;
					default:    io_oe_n[m] = ~goe_net[4'(oesel - `OESEL_GOE0)];
				endcase
				if (ctrl_ff[`CTRL_JTAG] && m >= NMC - `JTAG_PINS) begin
					io_oe_n[m] = 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mc_out_ff <= '0;
		end else begin
			mc_out_ff <= mc_out;
		end
	end

	assign io_out = mc_out_ff;
endmodule // cpld_macrocell_register_fabric

// ==== dv/cpld_fabric_assertions.sv ====
// assertions watching the macrocell fabric ports
`timescale 1ns/1ps
module fabric_checker (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        global_clock_pin_one,
	input wire logic        global_clear_pin_low,
	input wire logic        oe_pin_one,
	input wire logic [15:0] io_in,
	input wire logic [15:0] io_out,
	input wire logic [15:0] io_oe_n
);
	// shadow config snooped from completed writes; the checker sees no internals
	logic [31:0] ctrl_ff, clksel_ff, goe_ff, mode0_ff, mode12_ff;
	logic        wr_ev, init_ev, glob_d0;
	assign wr_ev   = psel && penable && pwrite && pready;
	assign init_ev = wr_ev && paddr == 12'h010 && pwdata[0];
	assign glob_d0 = mode0_ff[5:0] == 6'h00 && mode0_ff[8] && mode0_ff[14:12] == 3'h0 && clksel_ff[1:0] == 2'h0;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl_ff   <= 32'h0000_0001;
			clksel_ff <= 32'h0000_0000;
			goe_ff    <= 32'h0000_0000;
			mode0_ff  <= 32'h0000_0000;
			mode12_ff <= 32'h0000_0000;
		end else if (wr_ev) begin
			case (paddr)
				12'h000: ctrl_ff <= pwdata;
				12'h004: clksel_ff <= pwdata;
				12'h008: goe_ff <= pwdata;
				12'h43C: mode0_ff <= pwdata;
				12'h73C: mode12_ff <= pwdata;
				default: ;
			endcase
		end
	end
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	chk_unmapped_err: assert property (psel && !penable && paddr == 12'h014 |=> pslverr)
		else $error("no slave error on unmapped access");
	chk_global_clock: assert property ($rose(global_clock_pin_one) && glob_d0 && global_clear_pin_low |-> ##2 io_out[0] == $past(io_in[0], 2))
		else $error("global clock edge did not load pin");
	chk_clear_pin: assert property ((mode0_ff[6] && !global_clear_pin_low) [*2] |-> !io_out[0])
		else $error("global clear ignored");
	chk_init_high: assert property (init_ev && ctrl_ff[0] && mode0_ff[7] |-> ##[2:3] io_out[0])
		else $error("power-up high not loaded");
	chk_init_low: assert property (init_ev && !ctrl_ff[0] |-> ##[2:3] io_out == 16'h0000)
		else $error("power-up state not low");
	chk_scan_pins: assert property (ctrl_ff[1] |-> &io_oe_n[15:12])
		else $error("scan pins still driven");
	chk_goe_pin: assert property (mode12_ff[19:17] == 3'h2 && !ctrl_ff[1] && !goe_ff[0] |-> io_oe_n[12] == !(oe_pin_one ^ goe_ff[1]))
		else $error("enable pin not followed");
	chk_oe_fixed: assert property (mode12_ff[19:18] == 2'h0 && !ctrl_ff[1] |-> io_oe_n[12] == !mode12_ff[17])
		else $error("fixed enable wrong");
	cov_init: cover property (init_ev);
	cov_clock: cover property ($rose(global_clock_pin_one) && glob_d0);
	cov_scan: cover property (ctrl_ff[1]);
endmodule // fabric_checker

bind cpld_macrocell_register_fabric fabric_checker i_chk (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .global_clock_pin_one, .global_clear_pin_low, .oe_pin_one, .io_in, .io_out,
	.io_oe_n);

// ==== dv/board_pins_model.sv ====
// board logic model driving clock, clear, enable and pin inputs
`timescale 1ns/1ps
module board_pins_model (
	input  wire logic        sys_clk,
	output logic             clk_one,
	output logic             clk_two,
	output logic             clr_low,
	output logic             oe_one,
	output logic [15:0]      pins
);
	initial begin
		clk_one = 1'b0;
		clk_two = 1'b0;
		clr_low = 1'b1;
		oe_one  = 1'b0;
		pins    = 16'h0000;
	end
	// levels held several cycles: the fabric only sees what it samples
	task automatic set_one(input logic v);
		@(posedge sys_clk);
		clk_one <= v;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic set_two(input logic v);
		@(posedge sys_clk);
		clk_two <= v;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic drive(input logic [15:0] v, input logic c = 1'b1, input logic o = 1'b0);
		@(posedge sys_clk);
		pins    <= v;
		clr_low <= c;
		oe_one  <= o;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
endmodule // board_pins_model

// ==== dv/test_cpld_macrocell_register_fabric.sv ====
// self-checking bench for the macrocell fabric
`timescale 1ns/1ps
module test_cpld_macrocell_register_fabric;
	logic        sys_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic        err, clk_one, clk_two, clr_low, oe_one, pready, pslverr;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic [15:0] io_in, io_out, io_oe_n;
	int          miscompares = 0;
	int          checked     = 0;
	int          cycles      = 0;
	always #50 sys_clk = ~sys_clk;
	board_pins_model i_board (.sys_clk, .clk_one, .clk_two, .clr_low, .oe_one, .pins(io_in));
	cpld_macrocell_register_fabric i_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .global_clock_pin_one(clk_one), .global_clock_pin_two(clk_two),
		.global_clear_pin_low(clr_low), .oe_pin_one(oe_one), .io_in, .io_out, .io_oe_n);
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0000_0000);
		@(posedge sys_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic settle();
		repeat (3) @(negedge sys_clk);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// the run needs a few hundred cycles; this ceiling only catches a hang
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			final_report();
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		settle();
		check(32'(io_out), 32'h0000_0000);
		check(32'(io_oe_n), 32'h0000_FFFF);
		apb(1'b0, 12'h000);
		check(rd, 32'h0000_0001);
		apb(1'b0, 12'h014);
		check(32'(err), 32'h1);
		apb(1'b1, 12'h43C, 32'h0000_0140);
		i_board.drive(16'hFFF1);
		i_board.set_one(1'b1);
		check(32'(io_out[0]), 32'h1);
		apb(1'b0, 12'h00C);
		check(rd, 32'h0000_0001);
		i_board.set_one(1'b0);
		// inverted net: the write itself is a net rise and reloads the same pin value
		apb(1'b1, 12'h004, 32'h0000_0002);
		i_board.drive(16'h0000);
		i_board.set_one(1'b1);
		check(32'(io_out[0]), 32'h1);
		i_board.set_one(1'b0);
		check(32'(io_out[0]), 32'h0);
		// net 0 now follows the second clock pin, true polarity
		apb(1'b1, 12'h004, 32'h0000_0001);
		i_board.drive(16'h0001);
		i_board.set_two(1'b1);
		check(32'(io_out[0]), 32'h1);
		i_board.set_two(1'b0);
		i_board.drive(16'h0000);
		i_board.set_two(1'b1);
		check(32'(io_out[0]), 32'h0);
		i_board.set_two(1'b0);
		apb(1'b1, 12'h004, 32'h0000_0000);
		apb(1'b1, 12'h100, 32'h0000_0001);
		apb(1'b1, 12'h424, 32'h0000_0001);
		apb(1'b1, 12'h43C, 32'h0080_4148);
		i_board.drive(16'h0001);
		i_board.set_one(1'b1);
		check(32'(io_out[0]), 32'h0);
		i_board.set_one(1'b0);
		i_board.drive(16'h0003);
		i_board.set_one(1'b1);
		check(32'(io_out[0]), 32'h1);
		i_board.set_one(1'b0);
		apb(1'b1, 12'h43C, 32'h0080_4150);
		i_board.drive(16'h0000);
		i_board.drive(16'h0002);
		check(32'(io_out[0]), 32'h0);
		i_board.drive(16'h0001);
		i_board.drive(16'h0003);
		check(32'(io_out[0]), 32'h1);
		i_board.drive(16'h0003, 1'b0);
		check(32'(io_out[0]), 32'h0);
		i_board.drive(16'h0003);
		apb(1'b1, 12'h43C, 32'h0000_0080);
		apb(1'b1, 12'h010, 32'h0000_0001);
		settle();
		check(32'(io_out[0]), 32'h1);
		apb(1'b1, 12'h000, 32'h0000_0000);
		apb(1'b1, 12'h010, 32'h0000_0001);
		settle();
		check(32'(io_out), 32'h0000_0000);
		apb(1'b1, 12'h73C, 32'h0004_0000);
		i_board.drive(16'h0000, 1'b1, 1'b1);
		check(32'(io_oe_n[12]), 32'h0);
		i_board.drive(16'h0000);
		check(32'(io_oe_n[12]), 32'h1);
		// pin 12 driven again so the scan takeover has something to override
		i_board.drive(16'h0000, 1'b1, 1'b1);
		apb(1'b1, 12'h000, 32'h0000_0002);
		settle();
		check(32'(io_oe_n), 32'h0000_FFFF);
		final_report();
	end
endmodule // test_cpld_macrocell_register_fabric
